// *** hdl/rss_defines.vh ***
// register offsets, field positions, reset values and counts for the
// reset strap sampler; definitions only, included by the sampler module.
`ifndef RSS_DEFINES_VH
`define RSS_DEFINES_VH

// register byte offsets
`define RSS_OFF_CTRL        8'h00
`define RSS_OFF_MOTOR       8'h04
`define RSS_OFF_TESTOUT     8'h08
`define RSS_OFF_STATUS      8'h0C

// control register fields
`define RSS_CTRL_FOCUS_BIT  0
`define RSS_CTRL_SWLED_BIT  1
`define RSS_CTRL_PMIC_BIT   2
`define RSS_CTRL_RESET      3'h0

// motor register fields
`define RSS_MOTOR_EN_BIT    0
`define RSS_MOTOR_DATA_LSB  1
`define RSS_MOTOR_DATA_MSB  4
`define RSS_MOTOR_RESET     5'h00

// test output register
`define RSS_TESTOUT_RESET   7'h00

// status register fields
`define RSS_STAT_STRAP_MSB  6
`define RSS_STAT_VALID_BIT  8
`define RSS_STAT_TEST_BIT   9
`define RSS_STAT_AUTO_BIT   10
`define RSS_STAT_REFHI_BIT  11

// strap positions in the captured word
`define RSS_STRAP_AUTOINIT  5
`define RSS_STRAP_PLL_REFERENCE_CLOCK    6
`define RSS_TEST_MASK       7'h1F

// reference clock assumptions in kHz, pin low and pin high
`define RSS_PLL_REFERENCE_CLOCK_LOW_KHZ  16670
`define RSS_PLL_REFERENCE_CLOCK_HIGH_KHZ 48670

// cycles after reset release before the synchroniser output is trusted
`define RSS_CAPTURE_WAIT    2'h3

`endif

// *** hdl/rss_strap_sampler.v ***
// reset strap sampler: captures the multipurpose pins at reset release,
// then drives them as test or focus-motor outputs; also holds LED PWM high when idle.
// assumes one 25 MHz clock hclk, AHB-Lite slave with a single master.
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "rss_defines.vh"

// Functional notes
// - sample pins at release, then drive
// - weak pulldown gives low when open
// - pin zero is motor driver enable
// - pins one..four motor data, LSB first
// - auto-init strap picks flash or I2C
// - reference strap selects PLL frequency
// - LED PWM forced high when idle
module rss_strap_sampler #(
  parameter LED_CH = 3
) (
  input  wire              hclk,
  input  wire              hresetn,
  // ahb-lite slave
  input  wire              hsel,
  input  wire [7:0]        haddr,
  input  wire [1:0]        htrans,
  input  wire              hwrite,
  input  wire [2:0]        hsize,
  input  wire [31:0]       hwdata,
  input  wire              hready,
  output wire              hreadyout,
  output wire              hresp,
  output wire [31:0]       hrdata,
  // multipurpose pins
  input  wire              multipurpose_pin_zero_i,
  output wire              multipurpose_pin_zero_o,
  output wire              multipurpose_pin_zero_oe,
  input  wire              multipurpose_pin_one_i,
  output wire              multipurpose_pin_one_o,
  output wire              multipurpose_pin_one_oe,
  input  wire              multipurpose_pin_two_i,
  output wire              multipurpose_pin_two_o,
  output wire              multipurpose_pin_two_oe,
  input  wire              multipurpose_pin_three_i,
  output wire              multipurpose_pin_three_o,
  output wire              multipurpose_pin_three_oe,
  input  wire              multipurpose_pin_four_i,
  output wire              multipurpose_pin_four_o,
  output wire              multipurpose_pin_four_oe,
  input  wire              multipurpose_pin_five_i,
  output wire              multipurpose_pin_five_o,
  output wire              multipurpose_pin_five_oe,
  input  wire              pll_reference_clock_select_strap_i,
  output wire              pll_reference_clock_select_strap_o,
  output wire              pll_reference_clock_select_strap_oe,
  output wire              pin_pulldown_en,
  // decoded straps
  output wire              straps_valid,
  output wire              test_mode_en,
  output wire              flash_autoinit_en,
  output wire              i2c_flash_prog_en,
  output wire              pll_reference_clock_high,
  // led path
  input  wire              led_driver_enable,
  input  wire              led_sequence_active,
  input  wire [LED_CH-1:0] led_pwm_in,
  output wire [LED_CH-1:0] led_pwm_out
);

  localparam NPIN     = 7;
  localparam ST_WAIT  = 2'h0;
  localparam ST_CAPT  = 2'h1;
  localparam ST_RUN   = 2'h2;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  wire [NPIN-1:0] pin_in;
  reg  [NPIN-1:0] sync1_q;
  reg  [NPIN-1:0] sync2_q;
  reg  [NPIN-1:0] sync3_q;

  assign pin_in = {pll_reference_clock_select_strap_i, multipurpose_pin_five_i, multipurpose_pin_four_i,
                   multipurpose_pin_three_i, multipurpose_pin_two_i, multipurpose_pin_one_i,
                   multipurpose_pin_zero_i};

  genvar gp;
  generate
    for (gp = 0; gp < NPIN; gp = gp + 1) begin : g_sync
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sync1_q[gp] <= 1'b0;
          sync2_q[gp] <= 1'b0;
          sync3_q[gp] <= 1'b0;
        end else begin
          sync1_q[gp] <= pin_in[gp];
          sync2_q[gp] <= sync1_q[gp];
          sync3_q[gp] <= sync2_q[gp];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // capture sequencer
  // ----------------------------------------------------------------
  reg [1:0]      state_q;
  reg [1:0]      state_d;
  reg [1:0]      wait_q;
  reg [1:0]      wait_d;
  reg [NPIN-1:0] strap_q;
  reg            valid_q;
  wire           stable;

  // a capture counts only once stages two and three agree on every pin
  assign stable = (sync2_q == sync3_q);

  always @* begin
    state_d = state_q;
    wait_d  = wait_q;
    case (state_q)
      ST_WAIT: begin
        wait_d = wait_q + 2'h1;
        if (wait_q == `RSS_CAPTURE_WAIT - 2'h1) begin
          state_d = ST_CAPT;
        end
      end
      ST_CAPT: begin
        if (stable) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_WAIT;
        wait_d  = 2'h0;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_WAIT;
      wait_q  <= 2'h0;
      strap_q <= {NPIN{1'b0}};
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      wait_q  <= wait_d;
      if (state_q == ST_CAPT && stable) begin
        strap_q <= sync3_q;
        valid_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // strap decode
  // ----------------------------------------------------------------
  // pulldown held on while sampling
  assign pin_pulldown_en          = ~valid_q;
  assign straps_valid             = valid_q;
  // any high test-select strap enters test mode
  assign test_mode_en             = valid_q & (|(strap_q & `RSS_TEST_MASK));
  assign flash_autoinit_en        = valid_q & ~strap_q[`RSS_STRAP_AUTOINIT];
  assign i2c_flash_prog_en        = valid_q &  strap_q[`RSS_STRAP_AUTOINIT];
  assign pll_reference_clock_high = strap_q[`RSS_STRAP_PLL_REFERENCE_CLOCK];

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  reg  [2:0]  ctrl_q;
  reg  [4:0]  motor_q;
  reg  [6:0]  testout_q;
  reg  [31:0] rdata_q;
  reg         wr_pend_q;
  reg  [7:0]  wr_addr_q;
  wire        addr_phase;
  reg  [31:0] rd_mux;

  // zero wait state: every transfer finishes in its first data cycle
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = rdata_q;
  assign addr_phase = hsel & htrans[1] & hready;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (haddr)
      `RSS_OFF_CTRL: begin
        rd_mux[2:0] = ctrl_q;
      end
      `RSS_OFF_MOTOR: begin
        rd_mux[4:0] = motor_q;
      end
      `RSS_OFF_TESTOUT: begin
        rd_mux[6:0] = testout_q;
      end
      `RSS_OFF_STATUS: begin
        rd_mux[`RSS_STAT_STRAP_MSB:0] = strap_q;
        rd_mux[`RSS_STAT_VALID_BIT]   = valid_q;
        rd_mux[`RSS_STAT_TEST_BIT]    = test_mode_en;
        rd_mux[`RSS_STAT_AUTO_BIT]    = flash_autoinit_en;
        rd_mux[`RSS_STAT_REFHI_BIT]   = pll_reference_clock_high;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      rdata_q   <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_phase & hwrite;
      if (addr_phase) begin
        wr_addr_q <= haddr;
      end
      // read data sampled in the address phase, stands in the data phase
      if (addr_phase && !hwrite) begin
        rdata_q <= rd_mux;
      end
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q    <= `RSS_CTRL_RESET;
      motor_q   <= `RSS_MOTOR_RESET;
      testout_q <= `RSS_TESTOUT_RESET;
    end else if (wr_pend_q) begin
      case (wr_addr_q)
        `RSS_OFF_CTRL: begin
          ctrl_q <= hwdata[2:0];
        end
        `RSS_OFF_MOTOR: begin
          motor_q <= hwdata[4:0];
        end
        `RSS_OFF_TESTOUT: begin
          testout_q <= hwdata[6:0];
        end
        default: begin
          ctrl_q <= ctrl_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  reg  [NPIN-1:0] pin_out_q;
  reg  [NPIN-1:0] pin_oe_q;
  wire            focus_on;

  assign focus_on = ctrl_q[`RSS_CTRL_FOCUS_BIT];

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_q <= {NPIN{1'b0}};
      pin_oe_q  <= {NPIN{1'b0}};
    end else begin
      pin_oe_q <= {NPIN{valid_q}};
      if (focus_on) begin
        pin_out_q[0] <= motor_q[`RSS_MOTOR_EN_BIT];
        pin_out_q[4:1] <= motor_q[`RSS_MOTOR_DATA_MSB:`RSS_MOTOR_DATA_LSB];
        pin_out_q[6:5] <= testout_q[6:5];
      end else begin
        pin_out_q <= testout_q;
      end
    end
  end

  assign multipurpose_pin_zero_o   = pin_out_q[0];
  assign multipurpose_pin_one_o    = pin_out_q[1];
  assign multipurpose_pin_two_o    = pin_out_q[2];
  assign multipurpose_pin_three_o  = pin_out_q[3];
  assign multipurpose_pin_four_o   = pin_out_q[4];
  assign multipurpose_pin_five_o   = pin_out_q[5];
  assign pll_reference_clock_select_strap_o     = pin_out_q[6];
  assign multipurpose_pin_zero_oe  = pin_oe_q[0];
  assign multipurpose_pin_one_oe   = pin_oe_q[1];
  assign multipurpose_pin_two_oe   = pin_oe_q[2];
  assign multipurpose_pin_three_oe = pin_oe_q[3];
  assign multipurpose_pin_four_oe  = pin_oe_q[4];
  assign multipurpose_pin_five_oe  = pin_oe_q[5];
  assign pll_reference_clock_select_strap_oe    = pin_oe_q[6];

  // ----------------------------------------------------------------
  // led pwm forcing
  // ----------------------------------------------------------------
  reg  [LED_CH-1:0] led_q;
  wire              led_force;

  assign led_force = ~ctrl_q[`RSS_CTRL_PMIC_BIT] &
                     (~led_driver_enable | ~ctrl_q[`RSS_CTRL_SWLED_BIT] | ~led_sequence_active);

  genvar gl;
  generate
    for (gl = 0; gl < LED_CH; gl = gl + 1) begin : g_led
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          led_q[gl] <= 1'b1;
        end else begin
          led_q[gl] <= led_force | led_pwm_in[gl];
        end
      end
    end
  endgenerate

  assign led_pwm_out = led_q;

endmodule

`default_nettype wire

// *** sim/rss_board_model.sv ***
// board side of the multipurpose pins: strap resistors and motor driver chip
// assumes pads are resolved here from the sampler's drive and output enables
`timescale 1ns/10ps
`default_nettype none
module rss_board_model (
  input  wire logic [6:0] strap_up,
  input  wire logic [6:0] pin_o,
  input  wire logic [6:0] pin_oe,
  output wire logic [6:0] pad,
  output wire logic       motor_en,
  output wire logic [3:0] motor_word
);
  // pullups only where a scenario asks
  // open pads fall to the internal pulldown, never float
  assign pad = (pin_oe & pin_o) | (~pin_oe & strap_up);
  // driver chip simply listens to the pads
  assign motor_en   = pad[0];
  assign motor_word = pad[4:1];
endmodule
`default_nettype wire

// *** sim/rss_strap_sampler_sva.sv ***
// checker for the strap sampler's top ports
// assumes the power-management bit is set only while led driver and sequence run
`timescale 1ns/10ps
`default_nettype none
module rss_strap_sva #(
  parameter LED_CH = 3
) (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              straps_valid,
  input wire logic              pin_pulldown_en,
  input wire logic              test_mode_en,
  input wire logic              flash_autoinit_en,
  input wire logic              i2c_flash_prog_en,
  input wire logic              pll_reference_clock_high,
  input wire logic              multipurpose_pin_zero_i,
  input wire logic              multipurpose_pin_one_i,
  input wire logic              multipurpose_pin_two_i,
  input wire logic              multipurpose_pin_three_i,
  input wire logic              multipurpose_pin_four_i,
  input wire logic              multipurpose_pin_five_i,
  input wire logic              pll_reference_clock_select_strap_i,
  input wire logic              multipurpose_pin_zero_oe,
  input wire logic              multipurpose_pin_five_oe,
  input wire logic              pll_reference_clock_select_strap_oe,
  input wire logic              led_driver_enable,
  input wire logic              led_sequence_active,
  input wire logic [LED_CH-1:0] led_pwm_out
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic any_oe = multipurpose_pin_zero_oe | multipurpose_pin_five_oe | pll_reference_clock_select_strap_oe;
  wire logic test_pins = multipurpose_pin_zero_i | multipurpose_pin_one_i | multipurpose_pin_two_i
                       | multipurpose_pin_three_i | multipurpose_pin_four_i;
  pins_held_a :
    assert property (!straps_valid |-> !any_oe) else $error("pin driven before capture");
  oe_rise_a :
    assert property ($rose(straps_valid) |=> multipurpose_pin_zero_oe && multipurpose_pin_five_oe
                     && pll_reference_clock_select_strap_oe) else $error("pins not driven after capture");
  pulldown_on_a :
    assert property (!straps_valid |-> pin_pulldown_en) else $error("pulldown off before capture");
  test_cap_a :
    assert property ($rose(straps_valid) |-> test_mode_en == test_pins) else $error("test mode wrong");
  boot_sel_a :
    assert property ($rose(straps_valid) |-> i2c_flash_prog_en == multipurpose_pin_five_i
                     && flash_autoinit_en == !multipurpose_pin_five_i) else $error("boot source wrong");
  pll_reference_clock_cap_a :
    assert property ($rose(straps_valid) |-> pll_reference_clock_high == pll_reference_clock_select_strap_i)
    else $error("reference select wrong");
  straps_hold_a :
    assert property ($past(straps_valid) |-> straps_valid && $stable({test_mode_en, flash_autoinit_en,
                     i2c_flash_prog_en, pll_reference_clock_high})) else $error("straps changed");
  led_drv_off_a :
    assert property (!$past(led_driver_enable) |-> &led_pwm_out) else $error("led not forced");
  led_seq_off_a :
    assert property (!$past(led_sequence_active) |-> &led_pwm_out) else $error("led not forced");
  cover property ($rose(straps_valid));
  cover property (straps_valid && i2c_flash_prog_en);
  cover property (straps_valid && test_mode_en && pll_reference_clock_high);
endmodule
bind rss_strap_sampler rss_strap_sva #(.LED_CH(LED_CH)) chk_u (.hclk, .hresetn, .straps_valid,
  .pin_pulldown_en, .test_mode_en, .flash_autoinit_en, .i2c_flash_prog_en, .pll_reference_clock_high,
  .multipurpose_pin_zero_i, .multipurpose_pin_one_i, .multipurpose_pin_two_i, .multipurpose_pin_three_i,
  .multipurpose_pin_four_i, .multipurpose_pin_five_i, .pll_reference_clock_select_strap_i, .multipurpose_pin_zero_oe,
  .multipurpose_pin_five_oe, .pll_reference_clock_select_strap_oe, .led_driver_enable, .led_sequence_active,
  .led_pwm_out);
`default_nettype wire

// *** sim/tb_reset_strap_sampler.sv ***
// testbench for the strap sampler: straps, pin drive, LED forcing
// assumes a single AHB-Lite master and the board model on the pads
`timescale 1ns/10ps
`default_nettype none
`include "rss_defines.vh"
module tb_reset_strap_sampler;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        led_en = 1'b0;
  logic        led_seq = 1'b0;
  logic [2:0]  led_in = 3'h0;
  logic [6:0]  strap_up = 7'h00;
  wire logic   hreadyout, hresp, valid, tmode, auto_en, prog_en, refhi, pd_en, m_en;
  wire logic [31:0] hrdata;
  wire logic [6:0]  pad, po, poe;
  wire logic [2:0]  led_out;
  wire logic [3:0]  m_word;
  int err_count = 0;
  int cmp_count = 0;
  always #20 hclk = ~hclk;
  rss_strap_sampler dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata),
    .multipurpose_pin_zero_i(pad[0]), .multipurpose_pin_zero_o(po[0]), .multipurpose_pin_zero_oe(poe[0]),
    .multipurpose_pin_one_i(pad[1]), .multipurpose_pin_one_o(po[1]), .multipurpose_pin_one_oe(poe[1]),
    .multipurpose_pin_two_i(pad[2]), .multipurpose_pin_two_o(po[2]), .multipurpose_pin_two_oe(poe[2]),
    .multipurpose_pin_three_i(pad[3]), .multipurpose_pin_three_o(po[3]),
    .multipurpose_pin_three_oe(poe[3]), .multipurpose_pin_four_i(pad[4]), .multipurpose_pin_four_o(po[4]),
    .multipurpose_pin_four_oe(poe[4]), .multipurpose_pin_five_i(pad[5]), .multipurpose_pin_five_o(po[5]),
    .multipurpose_pin_five_oe(poe[5]), .pll_reference_clock_select_strap_i(pad[6]), .pll_reference_clock_select_strap_o(po[6]),
    .pll_reference_clock_select_strap_oe(poe[6]), .pin_pulldown_en(pd_en), .straps_valid(valid),
    .test_mode_en(tmode), .flash_autoinit_en(auto_en), .i2c_flash_prog_en(prog_en),
    .pll_reference_clock_high(refhi), .led_driver_enable(led_en), .led_sequence_active(led_seq),
    .led_pwm_in(led_in), .led_pwm_out(led_out));
  rss_board_model board_u (.strap_up(strap_up), .pin_o(po), .pin_oe(poe), .pad(pad),
    .motor_en(m_en), .motor_word(m_word));
  // ----------------------------------------
  // bus and checking tasks
  // ----------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // bounded wait: a slave that never answers ends the run
  task automatic rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_count++;
        results();
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, q, exp);
  endtask
  task automatic boot(input logic [6:0] s);
    int n;
    n = 0;
    hresetn <= 1'b0;
    strap_up <= s;
    repeat (20) @(posedge hclk);
    chk("oe in reset", {pd_en, poe}, {1'b1, 7'h00});
    hresetn <= 1'b1;
    while (valid !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_count++;
        results();
      end
      @(posedge hclk);
    end
    repeat (2) @(posedge hclk);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge hclk);
    err_count++;
    results();
  end
  initial begin
    boot(7'h00);
    rd("status open", `RSS_OFF_STATUS, 32'h500);
    chk("modes open", {tmode, auto_en, prog_en, refhi}, 4'b0100);
    chk("oe", {pd_en, hresp, poe}, {2'b00, 7'h7F});
    rd("unmapped", 8'h10, 32'h0);
    wr(`RSS_OFF_TESTOUT, 32'h55);
    repeat (2) @(posedge hclk);
    chk("test pads", pad, 7'h55);
    wr(`RSS_OFF_CTRL, 32'h1);
    wr(`RSS_OFF_MOTOR, 32'h07);
    repeat (2) @(posedge hclk);
    chk("motor", {m_en, m_word, pad[6:5]}, {1'b1, 4'h3, 2'b10});
    wr(`RSS_OFF_CTRL, 32'h3);
    led_in <= 3'h5;
    led_en <= 1'b1;
    led_seq <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("led pass", led_out, 3'h5);
    // driver off, sequence stopped, software control off
    for (int i = 0; i < 3; i++) begin
      wr(`RSS_OFF_CTRL, (i == 2) ? 32'h1 : 32'h3);
      led_en <= (i != 0);
      led_seq <= (i != 1);
      repeat (3) @(posedge hclk);
      chk("led forced", led_out, 3'h7);
    end
    // power-management chip present: no forcing, even with software control off
    wr(`RSS_OFF_CTRL, 32'h5);
    repeat (3) @(posedge hclk);
    chk("led pmic", led_out, 3'h5);
    rd("ctrl back", `RSS_OFF_CTRL, 32'h5);
    // board pulls a test pin up on purpose
    boot(7'h64);
    rd("status up", `RSS_OFF_STATUS, 32'hB64);
    chk("modes up", {tmode, auto_en, prog_en, refhi}, 4'b1011);
    chk("pads driven", pad, 7'h00);
    // pads now move under our own drive; the captured word must not follow
    strap_up <= 7'h00;
    wr(`RSS_OFF_TESTOUT, 32'h1B);
    repeat (5) @(posedge hclk);
    chk("pads follow", pad, 7'h1B);
    rd("status held", `RSS_OFF_STATUS, 32'hB64);
    results();
  end
endmodule
`default_nettype wire
